/* tla_pkg.sv */
package tla_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CONFIG = 3'h1;
   localparam logic [2:0] REG_TEMP   = 3'h2;
   localparam logic [2:0] REG_ID     = 3'h3;
   localparam logic [2:0] REG_CRIT   = 3'h4;
   localparam logic [2:0] REG_HYST   = 3'h5;
   localparam logic [2:0] REG_UPPER  = 3'h6;
   localparam logic [2:0] REG_LOWER  = 3'h7;

   // ----------------------------------------------------------------
   // Temperature scale and defaults
   // ----------------------------------------------------------------
   localparam int LSB_PER_DEGC   = 128;
   localparam int HYST_SHIFT     = 7;
   localparam int CRIT_RST_DEGC  = 147;
   localparam int UPPER_RST_DEGC = 64;
   localparam int LOWER_RST_DEGC = 10;
   localparam int RCG_TRIP_DEGC  = 180;
   localparam int RCG_REL_DEGC   = 138;
   localparam logic [15:0] CRIT_RST  = 16'(CRIT_RST_DEGC * LSB_PER_DEGC);
   localparam logic [15:0] UPPER_RST = 16'(UPPER_RST_DEGC * LSB_PER_DEGC);
   localparam logic [15:0] LOWER_RST = 16'(LOWER_RST_DEGC * LSB_PER_DEGC);
   localparam logic [15:0] TEMP_RST  = 16'h0000;
   localparam logic [7:0]  CONFIG_RST = 8'h00;
   localparam logic [7:0]  HYST_RST   = 8'h05;
   localparam logic [7:0]  STATUS_RST = 8'h80;
   localparam logic signed [15:0] RCG_TRIP =
      16'(RCG_TRIP_DEGC * LSB_PER_DEGC);
   localparam logic signed [15:0] RCG_REL =
      16'(RCG_REL_DEGC * LSB_PER_DEGC);

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CFG_CRIT_POL = 2;
   localparam int CFG_INT_POL  = 3;
   localparam int CFG_CMP_MODE = 4;
   localparam int CFG_OPM_LSB  = 5;
   localparam int CFG_OPM_MSB  = 6;
   localparam logic [1:0] OPM_SHUTDOWN = 2'h3;
   localparam int ST_RDY_N     = 7;
   localparam int ST_CRIT      = 6;
   localparam int ST_HIGH      = 5;
   localparam int ST_LOW       = 4;
   localparam int HYST_MSB     = 3;
   localparam int CMD_RW_BIT   = 6;
   localparam int CMD_ADDR_MSB = 5;
   localparam int CMD_ADDR_LSB = 3;
   localparam logic [7:0] CMD_ZERO_MASK = 8'h87;
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam logic [4:0] WORD_LAST = 5'h0f;
   localparam int SIF_RESET_ONES = 32;

   // ----------------------------------------------------------------
   // Serial framing states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TLA_CMD  = 3'b001,
      TLA_DATA = 3'b010,
      TLA_SKIP = 3'b100
   } tla_sif_t;

   // Registers that carry a 16-bit payload.
   function automatic logic tla_is_wide(input logic [2:0] a);
      return (a == REG_TEMP) || (a == REG_CRIT) ||
             (a == REG_UPPER) || (a == REG_LOWER);
   endfunction : tla_is_wide

endpackage : tla_pkg

/* tla_ones_det.sv */
`timescale 1ns/1ps
module tla_ones_det
   import tla_pkg::*;
#(
   parameter int ONES = SIF_RESET_ONES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic bit_stb,
   input  wire logic bit_val,
   output logic      sif_reset
);
   localparam int CW = $clog2(ONES + 1);
   localparam logic [CW-1:0] ONES_C = CW'(ONES);
   localparam logic [CW-1:0] ONE_C  = CW'(1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          fire_r;
   logic          fire_nxt;

   // Count consecutive ones; fire once on reaching the threshold and
   // hold there so a long run of ones does not re-fire.
   always_comb begin
      cnt_nxt  = cnt_r;
      fire_nxt = 1'b0;
      if (bit_stb) begin
         if (!bit_val) begin
            cnt_nxt = '0;
         end else if (cnt_r != ONES_C) begin
            cnt_nxt  = cnt_r + ONE_C;
            fire_nxt = (cnt_r + ONE_C) == ONES_C; // [RQ19]
         end
      end
   end

   // State registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r  <= '0;
         fire_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         fire_r <= fire_nxt;
      end
   end

   assign sif_reset = fire_r;
endmodule : tla_ones_det

/* tla_rcg.sv */
`timescale 1ns/1ps
module tla_rcg
   import tla_pkg::*;
#(
   parameter logic signed [15:0] TRIP = RCG_TRIP,
   parameter logic signed [15:0] REL  = RCG_REL
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        conv_stb,
   input  wire logic [15:0] temp,
   output logic             hold
);
   logic hold_r;
   logic hold_nxt;

   // Fixed trip and release points; software cannot move them, which
   // is the point of a backup that survives a bad limit write.
   always_comb begin
      hold_nxt = hold_r;
      if (conv_stb) begin
         if ($signed(temp) >= TRIP) begin
            hold_nxt = 1'b1; // [RQ10]
         end else if ($signed(temp) <= REL) begin
            hold_nxt = 1'b0; // [RQ11]
         end
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_r <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   assign hold = hold_r;
endmodule : tla_rcg

/* tla_alarm_top.sv */
// Notes on behaviour
// [RQ1] Alarm outputs start in interrupt mode.
// [RQ2] Limit alarm when above upper or below lower.
// [RQ3] Comparator mode releases past limit with hysteresis.
// [RQ4] Comparator mode: shutdown keeps limit alarm state.
// [RQ5] Interrupt mode: any register read clears alarm.
// [RQ6] After clear, only new conversion re-asserts.
// [RQ7] Interrupt mode: shutdown entry clears limit alarm.
// [RQ8] Critical alarm above critical limit, default 147.
// [RQ9] Backup generator owns critical output from 180.
// [RQ10] Backup generator trips at 180 degrees.
// [RQ11] Backup generator releases at 138 degrees.
// [RQ12] Continuous conversion runs from power-up.
// [RQ13] Host sends 32 ones to reset link.
// [RQ14] Identity register at 0x03 returns fixed code.
// [RQ15] Host checks registers against power-on defaults.
// [RQ16] Configuration at 0x01, temperature at 0x02.
// [RQ17] Hysteresis is four bits, 1 degree, default 5.
// [RQ18] Hysteresis lowers upper/critical, raises lower.
// [RQ19] Ones reset restores all registers to defaults.
// [RQ20] Host waits 500 us after link reset.
// [RQ21] Signed compares, once per completed conversion.
// [RQ22] Alarm output polarity is configurable.
`timescale 1ns/1ps
module tla_alarm_top
   import tla_pkg::*;
#(
   parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary identity value.
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   output logic             dout,
   output logic             dout_oe,
   input  wire logic        conv_stb,
   input  wire logic [15:0] conv_temp,
   output logic             conv_run,
   output logic [1:0]       conv_mode,
   output logic             int_o,
   output logic             int_oe,
   output logic             crit_o,
   output logic             crit_oe
);

   // ----------------------------------------------------------------
   // Serial edge detection
   // ----------------------------------------------------------------
   logic sclk_q_r;
   logic sclk_rise;
   logic sclk_fall;
   logic sif_reset;

   // Pins are already in the clock domain, so one delay flop suffices.
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_q_r <= 1'b1;
      end else begin
         sclk_q_r <= sclk;
      end
   end

   assign sclk_rise = sclk & ~sclk_q_r;
   assign sclk_fall = ~sclk & sclk_q_r;

   // Watches DIN even with chip select tied low, so a lost host can
   // always recover the link.
   tla_ones_det #(
      .ONES      (SIF_RESET_ONES)
   ) u_ones (
      .clk       (clk),
      .rst       (rst),
      .bit_stb   (sclk_rise),
      .bit_val   (din),
      .sif_reset (sif_reset)
   );

   // ----------------------------------------------------------------
   // Serial framing
   // ----------------------------------------------------------------
   tla_sif_t    state_r;
   tla_sif_t    state_nxt;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   logic [15:0] shin_r;
   logic [15:0] shin_nxt;
   logic [7:0]  cmd_r;
   logic [7:0]  cmd_nxt;
   logic [15:0] shout_r;
   logic [15:0] shout_nxt;
   logic        dout_r;
   logic        dout_nxt;
   logic        dout_oe_r;
   logic        dout_oe_nxt;
   logic        wr_stb;
   logic        rd_done;
   logic [15:0] rd_word;
   logic [2:0]  cmd_addr;
   logic [7:0]  new_cmd;

   assign cmd_addr = cmd_r[CMD_ADDR_MSB:CMD_ADDR_LSB];
   assign new_cmd  = {shin_r[6:0], din};

   // One command byte, then 8 or 16 data bits.  A malformed command
   // parks the framer until chip select rises or the link is reset.
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      shin_nxt    = shin_r;
      cmd_nxt     = cmd_r;
      shout_nxt   = shout_r;
      dout_nxt    = dout_r;
      dout_oe_nxt = dout_oe_r;
      wr_stb      = 1'b0;
      rd_done     = 1'b0;
      if (sif_reset || cs_n) begin
         state_nxt   = TLA_CMD;
         cnt_nxt     = '0;
         dout_oe_nxt = 1'b0;
      end else begin
         if (sclk_fall && state_r == TLA_DATA && cmd_r[CMD_RW_BIT]) begin
            dout_nxt    = shout_r[15];
            shout_nxt   = {shout_r[14:0], 1'b0};
            dout_oe_nxt = 1'b1;
         end
         if (sclk_rise) begin
            shin_nxt = {shin_r[14:0], din};
            cnt_nxt  = cnt_r + 5'h01;
            unique case (state_r)
               TLA_CMD: begin
                  if (cnt_r == BYTE_LAST) begin
                     cmd_nxt = new_cmd;
                     cnt_nxt = '0;
                     if ((new_cmd & CMD_ZERO_MASK) == 8'h00) begin
                        state_nxt = TLA_DATA;
                        shout_nxt = rd_word;
                     end else begin
                        state_nxt = TLA_SKIP;
                     end
                  end
               end
               TLA_DATA: begin
                  if (cnt_r == (tla_is_wide(cmd_addr) ? WORD_LAST
                                                      : BYTE_LAST)) begin
                     state_nxt = TLA_CMD;
                     cnt_nxt   = '0;
                     wr_stb    = ~cmd_r[CMD_RW_BIT];
                     rd_done   = cmd_r[CMD_RW_BIT];
                  end
               end
               TLA_SKIP: begin
                  cnt_nxt = '0;
               end
            endcase
         end
      end
   end

   // Framing registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r   <= TLA_CMD;
         cnt_r     <= '0;
         shin_r    <= '0;
         cmd_r     <= '0;
         shout_r   <= '0;
         dout_r    <= 1'b0;
         dout_oe_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         shin_r    <= shin_nxt;
         cmd_r     <= cmd_nxt;
         shout_r   <= shout_nxt;
         dout_r    <= dout_nxt;
         dout_oe_r <= dout_oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0]  config_r;
   logic [7:0]  config_nxt;
   logic [7:0]  hyst_r;
   logic [7:0]  hyst_nxt;
   logic [15:0] crit_lim_r;
   logic [15:0] crit_lim_nxt;
   logic [15:0] upper_r;
   logic [15:0] upper_nxt;
   logic [15:0] lower_r;
   logic [15:0] lower_nxt;
   logic [15:0] temp_r;
   logic [15:0] temp_nxt;
   logic        rdy_n_r;
   logic        rdy_n_nxt;
   logic [7:0]  status;
   logic        shutdown;
   logic        conv_acc;
   logic        shut_entry;
   logic        hi_act_r;
   logic        lo_act_r;
   logic        crit_act_r;
   logic [15:0] wr_data;

   assign wr_data  = {shin_r[14:0], din};
   assign shutdown = config_r[CFG_OPM_MSB:CFG_OPM_LSB] == OPM_SHUTDOWN;
   assign conv_acc = conv_stb & ~shutdown;
   assign shut_entry = wr_stb && cmd_addr == REG_CONFIG && !shutdown &&
      wr_data[CFG_OPM_MSB:CFG_OPM_LSB] == OPM_SHUTDOWN;

   // Status shows the not-ready flag and the live alarm states.
   always_comb begin
      status           = '0;
      status[ST_RDY_N] = rdy_n_r;
      status[ST_CRIT]  = crit_act_r;
      status[ST_HIGH]  = hi_act_r;
      status[ST_LOW]   = lo_act_r;
   end

   // Read data, left aligned so 8-bit registers shift out first.
   always_comb begin
      unique case (new_cmd[CMD_ADDR_MSB:CMD_ADDR_LSB])
         REG_STATUS: rd_word = {status, 8'h00};
         REG_CONFIG: rd_word = {config_r, 8'h00};
         REG_TEMP:   rd_word = temp_r;
         REG_ID:     rd_word = {ID_CODE, 8'h00}; // [RQ14]
         REG_CRIT:   rd_word = crit_lim_r;
         REG_HYST:   rd_word = {hyst_r, 8'h00};
         REG_UPPER:  rd_word = upper_r;
         REG_LOWER:  rd_word = lower_r;
      endcase
   end

   // Writes, conversions and the link reset.  A conversion landing in
   // the same cycle as a temperature read keeps the ready flag set.
   always_comb begin
      config_nxt   = config_r;
      hyst_nxt     = hyst_r;
      crit_lim_nxt = crit_lim_r;
      upper_nxt    = upper_r;
      lower_nxt    = lower_r;
      temp_nxt     = temp_r;
      rdy_n_nxt    = rdy_n_r;
      if (sif_reset) begin
         config_nxt   = CONFIG_RST; // [RQ19]
         hyst_nxt     = HYST_RST;
         crit_lim_nxt = CRIT_RST;
         upper_nxt    = UPPER_RST;
         lower_nxt    = LOWER_RST;
         temp_nxt     = TEMP_RST;
         rdy_n_nxt    = STATUS_RST[ST_RDY_N];
      end else begin
         if (wr_stb) begin
            unique case (cmd_addr)
               REG_CONFIG: config_nxt   = wr_data[7:0]; // [RQ16]
               REG_HYST:   hyst_nxt     = wr_data[7:0]; // [RQ17]
               REG_CRIT:   crit_lim_nxt = wr_data;
               REG_UPPER:  upper_nxt    = wr_data;
               REG_LOWER:  lower_nxt    = wr_data;
               default:    ;
            endcase
         end
         if (rd_done && cmd_addr == REG_TEMP) begin
            rdy_n_nxt = 1'b1;
         end
         if (conv_acc) begin
            temp_nxt  = conv_temp; // [RQ16]
            rdy_n_nxt = 1'b0;
         end
      end
   end

   // Register file storage.
   always_ff @(posedge clk) begin
      if (rst) begin
         config_r   <= CONFIG_RST; // [RQ1] [RQ12]
         hyst_r     <= HYST_RST;
         crit_lim_r <= CRIT_RST; // [RQ8]
         upper_r    <= UPPER_RST;
         lower_r    <= LOWER_RST;
         temp_r     <= TEMP_RST;
         rdy_n_r    <= STATUS_RST[ST_RDY_N];
      end else begin
         config_r   <= config_nxt;
         hyst_r     <= hyst_nxt;
         crit_lim_r <= crit_lim_nxt;
         upper_r    <= upper_nxt;
         lower_r    <= lower_nxt;
         temp_r     <= temp_nxt;
         rdy_n_r    <= rdy_n_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Limit comparison
   // ----------------------------------------------------------------
   logic signed [16:0] t17;
   logic signed [16:0] hy17;
   logic signed [16:0] up17;
   logic signed [16:0] lo17;
   logic signed [16:0] cr17;
   logic               over_hi;
   logic               under_lo;
   logic               over_cr;
   logic               rel_hi;
   logic               rel_lo;
   logic               rel_cr;
   logic               hi_act_nxt;
   logic               lo_act_nxt;
   logic               crit_act_nxt;
   logic               cmp_mode;
   logic               rcg_hold;

   // One extra bit keeps limit plus or minus hysteresis from wrapping.
   assign t17  = {conv_temp[15], conv_temp}; // [RQ21]
   assign up17 = {upper_r[15], upper_r};
   assign lo17 = {lower_r[15], lower_r};
   assign cr17 = {crit_lim_r[15], crit_lim_r};
   assign hy17 = signed'(17'(hyst_r[HYST_MSB:0]) << HYST_SHIFT);
   assign over_hi  = t17 > up17; // [RQ2]
   assign under_lo = t17 < lo17; // [RQ2]
   assign over_cr  = t17 > cr17; // [RQ8]
   assign rel_hi   = t17 < (up17 - hy17); // [RQ18]
   assign rel_lo   = t17 > (lo17 + hy17); // [RQ18]
   assign rel_cr   = t17 < (cr17 - hy17); // [RQ18]
   assign cmp_mode = config_r[CFG_CMP_MODE];

   // Clears come first so that an event in the same cycle wins.
   always_comb begin
      hi_act_nxt   = hi_act_r;
      lo_act_nxt   = lo_act_r;
      crit_act_nxt = crit_act_r;
      if (sif_reset) begin
         hi_act_nxt   = 1'b0;
         lo_act_nxt   = 1'b0;
         crit_act_nxt = 1'b0;
      end else begin
         if (!cmp_mode && (rd_done || shut_entry)) begin
            hi_act_nxt   = 1'b0; // [RQ5] [RQ7]
            lo_act_nxt   = 1'b0;
            crit_act_nxt = 1'b0;
         end
         // Shutdown stops conversions, so comparator state just holds.
         if (conv_acc) begin // [RQ4] [RQ21]
            if (cmp_mode) begin
               hi_act_nxt   = over_hi  | (hi_act_r   & ~rel_hi); // [RQ3]
               lo_act_nxt   = under_lo | (lo_act_r   & ~rel_lo); // [RQ3]
               crit_act_nxt = over_cr  | (crit_act_r & ~rel_cr);
            end else begin
               hi_act_nxt   = hi_act_nxt   | over_hi; // [RQ6]
               lo_act_nxt   = lo_act_nxt   | under_lo; // [RQ6]
               crit_act_nxt = crit_act_nxt | over_cr;
            end
         end
      end
   end

   // Alarm state registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         hi_act_r   <= 1'b0;
         lo_act_r   <= 1'b0;
         crit_act_r <= 1'b0;
      end else begin
         hi_act_r   <= hi_act_nxt;
         lo_act_r   <= lo_act_nxt;
         crit_act_r <= crit_act_nxt;
      end
   end

   // Backup critical path sees every conversion taken outside shutdown.
   tla_rcg #(
      .TRIP     (RCG_TRIP),
      .REL      (RCG_REL)
   ) u_rcg (
      .clk      (clk),
      .rst      (rst),
      .conv_stb (conv_acc),
      .temp     (conv_temp),
      .hold     (rcg_hold)
   );

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   logic int_oe_r;
   logic int_oe_nxt;
   logic crit_oe_r;
   logic crit_oe_nxt;
   logic run_r;
   logic run_nxt;
   logic [1:0] mode_r;
   logic [1:0] mode_nxt;

   // Open drain: polarity 0 pulls low while active, 1 pulls low while
   // inactive, so the pull-up shows the active level.
   always_comb begin
      int_oe_nxt  = config_r[CFG_INT_POL] ^ (hi_act_r | lo_act_r); // [RQ22]
      crit_oe_nxt = config_r[CFG_CRIT_POL] ^ (crit_act_r | rcg_hold); // [RQ9]
      run_nxt     = ~shutdown; // [RQ12]
      mode_nxt    = config_r[CFG_OPM_MSB:CFG_OPM_LSB];
   end

   // Output registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         int_oe_r  <= 1'b0;
         crit_oe_r <= 1'b0;
         run_r     <= 1'b1;
         mode_r    <= CONFIG_RST[CFG_OPM_MSB:CFG_OPM_LSB];
      end else begin
         int_oe_r  <= int_oe_nxt;
         crit_oe_r <= crit_oe_nxt;
         run_r     <= run_nxt;
         mode_r    <= mode_nxt;
      end
   end

   assign dout      = dout_r;
   assign dout_oe   = dout_oe_r;
   assign int_o     = 1'b0;
   assign int_oe    = int_oe_r;
   assign crit_o    = 1'b0;
   assign crit_oe   = crit_oe_r;
   assign conv_run  = run_r;
   assign conv_mode = mode_r;

endmodule : tla_alarm_top

/* tla_alarm_top_assertions.sv */
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module tla_chk
   import tla_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        dout,
   input wire logic        dout_oe,
   input wire logic        conv_stb,
   input wire logic [15:0] conv_temp,
   input wire logic        conv_run,
   input wire logic [1:0]  conv_mode,
   input wire logic        int_o,
   input wire logic        crit_o,
   input wire logic        crit_oe
);
   logic hold_r;
   logic hold_nxt;
   logic trip;
   logic rel;
   // Backup trip mirror; a link reset must not clear it.
   assign trip = conv_stb && conv_run && $signed(conv_temp) >= RCG_TRIP;
   assign rel  = conv_stb && conv_run && $signed(conv_temp) <= RCG_REL;
   always_comb begin
      hold_nxt = trip ? 1'b1 : (rel ? 1'b0 : hold_r);
   end
   always_ff @(posedge clk) begin
      hold_r <= rst ? 1'b0 : hold_nxt;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Critical checks assume the low-active pin setting the bench keeps.
   a_int_pin_low: assert property (!int_o)
      else $error("int_o driven high");
   a_crit_pin_low: assert property (!crit_o)
      else $error("crit_o driven high");
   a_run_mode_match: assert property (
      conv_run == (conv_mode != OPM_SHUTDOWN))
      else $error("conv_run disagrees with conv_mode");
   a_backup_trip: assert property (trip |-> ##2 crit_oe)
      else $error("backup trip not seen on crit_oe");
   a_backup_keep: assert property (hold_r |=> crit_oe)
      else $error("crit_oe released while backup holds");
   a_crit_rise_conv: assert property (
      $rose(crit_oe) |-> $past(conv_stb, 2))
      else $error("crit_oe rose without a conversion");
   a_oe_needs_sel: assert property (dout_oe |-> !$past(cs_n))
      else $error("dout_oe while deselected");
   a_dout_on_fall: assert property (
      $changed(dout) && dout_oe |-> !$past(sclk) && $past(sclk, 2))
      else $error("dout moved off a clock fall");
   c_backup_held: cover property (hold_r);
   c_read_data: cover property (dout_oe);
   c_shutdown: cover property (!conv_run);
endmodule : tla_chk

bind tla_alarm_top tla_chk u_chk (.clk(clk), .rst(rst), .sclk(sclk),
   .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .conv_stb(conv_stb),
   .conv_temp(conv_temp), .conv_run(conv_run), .conv_mode(conv_mode),
   .int_o(int_o), .crit_o(crit_o), .crit_oe(crit_oe));

/* tla_host.sv */
`timescale 1ns/1ps
// ----------
// Host model
// ----------
module tla_host (
   input wire logic clk,
   input wire logic dout,
   output logic     sclk,
   output logic     cs_n,
   output logic     din
);
   // Clock idles high and stands still outside frames and link resets.
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   // One frame; each phase lasts several clk so the device sees it.
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                       output logic [15:0] rd);
      logic [23:0] sh;
      int          nb;
      nb = (cmd[5:3] inside {3'h2, 3'h4, 3'h6, 3'h7}) ? 16 : 8;
      sh = (nb == 16) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
      rd = 16'h0000;
      @(posedge clk);
      cs_n <= 1'b0;
      for (int i = 0; i < 8 + nb; i++) begin
         @(posedge clk);
         sclk <= 1'b0;
         din  <= sh[23-i];
         repeat (3) @(posedge clk);
         if (i >= 8) begin
            rd = {rd[14:0], dout};
         end
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
      end
      cs_n <= 1'b1;
      din  <= ~din;
      // Let the pins launched by the last rise settle before callers look.
      @(posedge clk);
   endtask : xfer
   // Ones on the data line reset the link; then the host keeps quiet.
   task automatic link_reset();
      din <= 1'b1;
      repeat (32) begin
         @(posedge clk);
         sclk <= 1'b0;
         repeat (2) @(posedge clk);
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
      end
      din <= 1'b0;
      repeat (20000) @(posedge clk);
   endtask : link_reset
endmodule : tla_host

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import tla_pkg::*;
;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value.
   localparam logic signed [15:0] UP = 16'h2000;
   localparam logic signed [15:0] LO = 16'h0500;
   localparam logic signed [15:0] HY = 16'h0280;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic conv_stb = 1'b0;
   logic [15:0] conv_temp = 16'h0000;
   logic sclk, cs_n, din, dout, dout_oe, conv_run, int_o, int_oe;
   logic crit_o, crit_oe;
   logic [1:0] conv_mode;
   logic [15:0] v;
   logic hi, lo;
   logic signed [15:0] t;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [2:0] da[5] = '{3'h1, 3'h4, 3'h6, 3'h7, 3'h5};
   logic [15:0] de[5] = '{16'h0, 16'h4980, UP, LO, 16'h5};
   logic signed [15:0] corner[6] = '{UP, UP + 1, UP - HY, UP - HY - 1,
                                     LO - 1, LO + HY + 1};

   always #12.5 clk = ~clk;

   tla_alarm_top #(.ID_CODE(ID)) u_tla_alarm_top (.clk(clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
      .conv_stb(conv_stb), .conv_temp(conv_temp), .conv_run(conv_run),
      .conv_mode(conv_mode), .int_o(int_o), .int_oe(int_oe),
      .crit_o(crit_o), .crit_oe(crit_oe));
   tla_host u_tla_host (.clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n),
      .din(din));

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rd(logic [2:0] a, output logic [15:0] d);
      u_tla_host.xfer({2'b01, a, 3'b000}, 16'h0, d);
   endtask : rd
   task automatic wr(logic [2:0] a, logic [15:0] d);
      logic [15:0] x;
      u_tla_host.xfer({2'b00, a, 3'b000}, d, x);
   endtask : wr
   // Alarm pins settle two clk after the strobe is taken.
   task automatic conv(logic [15:0] tv);
      @(posedge clk);
      conv_stb  <= 1'b1;
      conv_temp <= tv;
      @(posedge clk);
      conv_stb <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : conv
   // Comparator-mode expectation with the default limits.
   function automatic void cmp(logic signed [15:0] x, inout logic h, l);
      h = (x > UP) ? 1'b1 : ((x < UP - HY) ? 1'b0 : h);
      l = (x < LO) ? 1'b1 : ((x > LO + HY) ? 1'b0 : l);
   endfunction : cmp
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         n_fail++;
         final_report();
      end
   end

   initial begin
      void'($urandom(60144));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      u_tla_host.link_reset();
      chk("run", 1, 16'(conv_run));
      wr(REG_ID, 16'hff);
      repeat (2) begin
         rd(REG_ID, v);
         chk("id", 16'(ID), v);
      end
      foreach (da[i]) begin
         rd(da[i], v);
         chk("default", de[i], v);
      end
      conv(16'h2001);
      chk("int high", 1, 16'(int_oe));
      rd(REG_STATUS, v);
      chk("int read", 0, 16'(int_oe));
      conv(16'h1000);
      chk("int quiet", 0, 16'(int_oe));
      conv(16'h04ff);
      chk("int low", 1, 16'(int_oe));
      wr(REG_CONFIG, 16'h60);
      chk("int sd", 0, 16'(int_oe));
      conv(16'h2001);
      chk("sd conv", 0, 16'(int_oe));
      wr(REG_CONFIG, 16'h00);
      conv(16'h4981);
      chk("crit", 1, 16'(crit_oe));
      conv(16'h5a00);
      rd(REG_STATUS, v);
      chk("backup", 1, 16'(crit_oe));
      conv(16'h4501);
      chk("backup hold", 1, 16'(crit_oe));
      conv(16'h4500);
      chk("backup off", 0, 16'(crit_oe));
      wr(REG_CONFIG, 16'h10);
      conv(16'h1000);
      hi = 1'b0;
      lo = 1'b0;
      for (int i = 0; i < 120; i++) begin
         t = 16'($urandom_range(16'h3fff)) - 16'sh1000;
         if (i % 5 == 0) begin
            t = corner[$urandom_range(5)];
         end
         conv(t);
         cmp(t, hi, lo);
         if (i == 7) begin
            rd(REG_STATUS, v);
         end
         chk("cmp int", 16'(hi | lo), 16'(int_oe));
      end
      conv(16'h2001);
      wr(REG_CONFIG, 16'h70);
      chk("cmp sd", 1, 16'(int_oe));
      wr(REG_CONFIG, 16'h08);
      conv(16'h0a5a);
      rd(REG_TEMP, v);
      chk("temp", 16'h0a5a, v);
      chk("int pol", 1, 16'(int_oe));
      wr(REG_UPPER, 16'h1234);
      u_tla_host.link_reset();
      rd(REG_UPPER, v);
      chk("upper", 16'(UP), v);
      rd(REG_CONFIG, v);
      chk("config", 0, v);
      final_report();
   end
endmodule : tb_top
